// ---- ccs_pkg.sv ----
// constants for the command and status bits of the configuration header
package ccs_pkg;
    localparam int CCS_REG_W = 16;
    localparam logic [7:0] CCS_CMD_OFS = 8'h04;
    localparam logic [7:0] CCS_STS_OFS = 8'h06;
    // command bit positions
    localparam int CCS_CMD_PERR_RESP = 6;
    localparam int CCS_CMD_STEP = 7;
    localparam int CCS_CMD_SERR_EN = 8;
    localparam int CCS_CMD_FBB_EN = 9;
    localparam int CCS_CMD_INT_DIS = 10;
    // status bit positions
    localparam int CCS_STS_INT_PEND = 3;
    localparam int CCS_STS_CAP_LIST = 4;
    localparam int CCS_STS_SPEED = 5;
    localparam int CCS_STS_FBB_CAP = 7;
    localparam int CCS_STS_MDPE = 8;
    localparam int CCS_STS_SEL_LO = 9;
    localparam int CCS_STS_SEL_HI = 10;
    localparam int CCS_STS_SIG_TABT = 11;
    localparam int CCS_STS_SIG_SERR = 14;
    localparam logic CCS_RST_BIT = 1'h0;
    localparam logic CCS_CAP_PRESENT = 1'h1;
    localparam logic [15:0] CCS_ZERO16 = 16'h0000;
endpackage

// ---- ccs_w1c_flag.sv ----
// one write-one-to-clear status flag where a set beats a clear
`timescale 1ns/100ps
`default_nettype none
module ccs_w1c_flag
    import ccs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_nxt;
    // set wins so an event on the clearing cycle is kept
    assign flag_nxt = set_i | (flag_o & ~clr_i);
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flag_o <= CCS_RST_BIT;
        else
            flag_o <= flag_nxt;
    end
endmodule
`default_nettype wire

// ---- ccs_cmd_status.sv ----
// command bits 6..10 and status bits 3..11,14 of the configuration header
`timescale 1ns/100ps
`default_nettype none
module ccs_cmd_status
    import ccs_pkg::*;
#(
    parameter bit SERR_IMPL = 1'h1
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic [1:0] cfg_be,
    input wire logic cfg_rd,
    output logic [15:0] cfg_rdata,
    input wire logic own_int_req,
    input wire logic fwd_int_req,
    input wire logic err_nonfatal_det,
    input wire logic err_fatal_det,
    input wire logic dev_nonfatal_en,
    input wire logic dev_fatal_en,
    input wire logic fwd_err_nonfatal,
    input wire logic fwd_err_fatal,
    input wire logic fwd_err_cor,
    input wire logic poisoned_cpl_rx,
    input wire logic poisoned_wr_tx,
    input wire logic cpl_abort_tx,
    output logic int_assert_o,
    output logic fwd_int_o,
    output logic send_nonfatal_o,
    output logic send_fatal_o,
    output logic send_cor_o,
    output logic serr_en_o,
    output logic perr_resp_o,
    output logic int_dis_o
);
    // ----------------------------------------
    // register access decode
    // ----------------------------------------
    wire cmd_sel = cfg_addr == CCS_CMD_OFS;
    wire sts_sel = cfg_addr == CCS_STS_OFS;
    wire cmd_wr_lo = cfg_wr & cmd_sel & cfg_be[0];
    wire cmd_wr_hi = cfg_wr & cmd_sel & cfg_be[1];
    // low status byte is all read-only, so only the high lane can clear
    wire sts_wr_hi = cfg_wr & sts_sel & cfg_be[1];

    // ----------------------------------------
    // command control bits
    // ----------------------------------------
    logic perr_resp_r;
    logic serr_en_r;
    logic int_dis_r;
    logic perr_resp_nxt;
    logic serr_en_nxt;
    logic int_dis_nxt;
    // bits 7 and 9 have no storage, so writes to them vanish
    assign perr_resp_nxt = cmd_wr_lo ? cfg_wdata[CCS_CMD_PERR_RESP] : perr_resp_r;
    // tied low when the function has no event collector
    assign serr_en_nxt = SERR_IMPL & (cmd_wr_hi ? cfg_wdata[CCS_CMD_SERR_EN] : serr_en_r);
    assign int_dis_nxt = cmd_wr_hi ? cfg_wdata[CCS_CMD_INT_DIS] : int_dis_r;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            perr_resp_r <= CCS_RST_BIT;
            serr_en_r <= CCS_RST_BIT;
            int_dis_r <= CCS_RST_BIT;
        end
        else
        begin
            perr_resp_r <= perr_resp_nxt;
            serr_en_r <= serr_en_nxt;
            int_dis_r <= int_dis_nxt;
        end
    end

    // ----------------------------------------
    // error reporting
    // ----------------------------------------
    wire own_nf = err_nonfatal_det & (serr_en_r | dev_nonfatal_en);
    wire own_f = err_fatal_det & (serr_en_r | dev_fatal_en);
    wire fw_nf = fwd_err_nonfatal & serr_en_r;
    wire fw_f = fwd_err_fatal & serr_en_r;
    wire nf_nxt = own_nf | fw_nf;
    wire f_nxt = own_f | fw_f;
    // flag only when this enable is the one that lets the message out
    wire sig_serr_set = serr_en_r & (nf_nxt | f_nxt);

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    wire mdpe_set = perr_resp_r & (poisoned_cpl_rx | poisoned_wr_tx);
    wire mdpe_clr = sts_wr_hi & cfg_wdata[CCS_STS_MDPE];
    wire tabt_clr = sts_wr_hi & cfg_wdata[CCS_STS_SIG_TABT];
    wire serr_clr = sts_wr_hi & cfg_wdata[CCS_STS_SIG_SERR];
    logic mdpe_q;
    logic tabt_q;
    logic sserr_q;
    ccs_w1c_flag u_mdpe
    (
        .clk(clk),
        .reset_n(reset_n),
        .set_i(mdpe_set),
        .clr_i(mdpe_clr),
        .flag_o(mdpe_q)
    );
    ccs_w1c_flag u_tabt
    (
        .clk(clk),
        .reset_n(reset_n),
        .set_i(cpl_abort_tx),
        .clr_i(tabt_clr),
        .flag_o(tabt_q)
    );
    ccs_w1c_flag u_sserr
    (
        .clk(clk),
        .reset_n(reset_n),
        .set_i(sig_serr_set),
        .clr_i(serr_clr),
        .flag_o(sserr_q)
    );

    // ----------------------------------------
    // legacy interrupt
    // ----------------------------------------
    // pending follows own source only; forwarded ones never show here
    logic int_pend_r;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            int_pend_r <= CCS_RST_BIT;
        else
            int_pend_r <= own_int_req;
    end
    // disable drops an asserted interrupt on the next edge
    wire int_assert_nxt = own_int_req & ~int_dis_nxt;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [15:0] cmd_view;
    logic [15:0] sts_view;
    always_comb
    begin
        cmd_view = CCS_ZERO16;
        cmd_view[CCS_CMD_PERR_RESP] = perr_resp_r;
        cmd_view[CCS_CMD_SERR_EN] = serr_en_r;
        cmd_view[CCS_CMD_INT_DIS] = int_dis_r;
        sts_view = CCS_ZERO16;
        sts_view[CCS_STS_INT_PEND] = int_pend_r;
        sts_view[CCS_STS_CAP_LIST] = CCS_CAP_PRESENT;
        sts_view[CCS_STS_MDPE] = mdpe_q;
        sts_view[CCS_STS_SIG_TABT] = tabt_q;
        sts_view[CCS_STS_SIG_SERR] = sserr_q;
    end
    wire [15:0] rdata_nxt = !cfg_rd ? CCS_ZERO16 : cmd_sel ? cmd_view :
        sts_sel ? sts_view : CCS_ZERO16;

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_rdata <= CCS_ZERO16;
            int_assert_o <= CCS_RST_BIT;
            fwd_int_o <= CCS_RST_BIT;
            send_nonfatal_o <= CCS_RST_BIT;
            send_fatal_o <= CCS_RST_BIT;
            send_cor_o <= CCS_RST_BIT;
            serr_en_o <= CCS_RST_BIT;
            perr_resp_o <= CCS_RST_BIT;
            int_dis_o <= CCS_RST_BIT;
        end
        else
        begin
            cfg_rdata <= rdata_nxt;
            int_assert_o <= int_assert_nxt;
            fwd_int_o <= fwd_int_req;
            send_nonfatal_o <= nf_nxt;
            send_fatal_o <= f_nxt;
            send_cor_o <= fwd_err_cor;
            serr_en_o <= serr_en_nxt;
            perr_resp_o <= perr_resp_nxt;
            int_dis_o <= int_dis_nxt;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    cmd_ro_zero_a: assert property (cfg_rd && cmd_sel |=> !cfg_rdata[CCS_CMD_STEP]
        && !cfg_rdata[CCS_CMD_FBB_EN]) else $error("command tied bits nonzero");
    sts_ro_zero_a: assert property (cfg_rd && sts_sel |=> !cfg_rdata[CCS_STS_SPEED]
        && !cfg_rdata[CCS_STS_FBB_CAP] && !cfg_rdata[CCS_STS_SEL_LO]
        && !cfg_rdata[CCS_STS_SEL_HI]) else $error("status tied bits nonzero");
    cap_list_one_a: assert property (cfg_rd && sts_sel |=> cfg_rdata[CCS_STS_CAP_LIST])
        else $error("capability bit low");
    serr_write_a: assert property (cmd_wr_hi |=> serr_en_r == (SERR_IMPL &
        $past(cfg_wdata[CCS_CMD_SERR_EN]))) else $error("enable write lost");
    err_report_a: assert property (err_fatal_det && (serr_en_r || dev_fatal_en)
        |=> send_fatal_o) else $error("fatal error not sent");
    fwd_gate_a: assert property (fwd_err_nonfatal && !serr_en_r && !err_nonfatal_det
        |=> !send_nonfatal_o) else $error("forwarded error leaked");
    int_block_a: assert property (int_dis_r |-> !int_assert_o)
        else $error("interrupt while disabled");
    int_drop_a: assert property (cmd_wr_hi && cfg_wdata[CCS_CMD_INT_DIS]
        |=> !int_assert_o) else $error("interrupt not dropped");
    mdpe_gate_a: assert property (!perr_resp_r && !mdpe_q |=> !mdpe_q)
        else $error("parity flag set while off");
    mdpe_set_a: assert property (perr_resp_r && poisoned_cpl_rx |=> mdpe_q)
        else $error("parity flag missed");
    tabt_keep_a: assert property (tabt_q && !tabt_clr |=> tabt_q)
        else $error("abort flag lost");
    tabt_set_a: assert property (cpl_abort_tx |=> tabt_q)
        else $error("abort flag missed");
    sserr_set_a: assert property (serr_en_r && err_fatal_det |=> sserr_q)
        else $error("system error flag missed");

    // ----------------------------------------
    // assertions: register access
    // ----------------------------------------
    perr_write_a: assert property (cmd_wr_lo
        |=> perr_resp_r == $past(cfg_wdata[CCS_CMD_PERR_RESP]))
        else $error("parity response write lost");

    int_dis_write_a: assert property (cmd_wr_hi
        |=> int_dis_r == $past(cfg_wdata[CCS_CMD_INT_DIS]))
        else $error("interrupt disable write lost");

    cmd_keep_a: assert property (!cmd_wr_lo && !cmd_wr_hi
        |=> $stable(perr_resp_r) && $stable(serr_en_r) && $stable(int_dis_r))
        else $error("command bits changed without write");

    other_addr_a: assert property (cfg_rd && !cmd_sel && !sts_sel
        |=> cfg_rdata == CCS_ZERO16)
        else $error("unmapped read not zero");

    cmd_read_a: assert property (cfg_rd && cmd_sel
        |=> cfg_rdata[CCS_CMD_SERR_EN] == $past(serr_en_r)
        && cfg_rdata[CCS_CMD_INT_DIS] == $past(int_dis_r))
        else $error("command read data wrong");

    // ----------------------------------------
    // assertions: legacy interrupt
    // ----------------------------------------
    pend_read_a: assert property (cfg_rd && sts_sel && $past(own_int_req)
        && $past(reset_n) |=> cfg_rdata[CCS_STS_INT_PEND])
        else $error("pending bit missed");

    pend_fwd_a: assert property (cfg_rd && sts_sel && !$past(own_int_req)
        |=> !cfg_rdata[CCS_STS_INT_PEND])
        else $error("pending shows forwarded interrupt");

    int_on_a: assert property (own_int_req && !int_dis_r && !cmd_wr_hi
        |=> int_assert_o)
        else $error("enabled interrupt not asserted");

    fwd_int_a: assert property (fwd_int_req && int_dis_r
        |=> fwd_int_o)
        else $error("forwarded interrupt blocked");

    // ----------------------------------------
    // assertions: error messages
    // ----------------------------------------
    nf_report_a: assert property (err_nonfatal_det && (serr_en_r || dev_nonfatal_en)
        |=> send_nonfatal_o)
        else $error("nonfatal error not sent");

    own_mask_a: assert property (err_fatal_det && !serr_en_r && !dev_fatal_en
        && !fwd_err_fatal |=> !send_fatal_o)
        else $error("masked fatal error sent");

    fwd_fatal_a: assert property (fwd_err_fatal && serr_en_r
        |=> send_fatal_o)
        else $error("forwarded fatal not sent");

    cor_pass_a: assert property (fwd_err_cor
        |=> send_cor_o)
        else $error("forwarded correctable dropped");

    sserr_gate_a: assert property (!serr_en_r && !sserr_q
        |=> !sserr_q)
        else $error("system error flag set while off");

    sserr_fwd_a: assert property (serr_en_r && fwd_err_fatal
        |=> sserr_q)
        else $error("forwarded error flag missed");

    // ----------------------------------------
    // assertions: status flags
    // ----------------------------------------
    mdpe_wr_a: assert property (perr_resp_r && poisoned_wr_tx
        |=> mdpe_q)
        else $error("poisoned write flag missed");

    mdpe_clear_a: assert property (mdpe_clr && !poisoned_cpl_rx && !poisoned_wr_tx
        |=> !mdpe_q)
        else $error("parity flag not cleared");

    mdpe_keep_a: assert property (mdpe_q && !mdpe_clr
        |=> mdpe_q)
        else $error("parity flag lost");

    tabt_clear_a: assert property (tabt_clr && !cpl_abort_tx
        |=> !tabt_q)
        else $error("abort flag not cleared");

    sserr_clear_a: assert property (serr_clr && !err_fatal_det && !err_nonfatal_det
        && !fwd_err_fatal && !fwd_err_nonfatal |=> !sserr_q)
        else $error("system error flag not cleared");

    // ----------------------------------------
    // cover points
    // ----------------------------------------
    int_drop_c: cover property (int_assert_o ##1 !int_assert_o && int_dis_r);
    mdpe_clear_c: cover property (mdpe_q ##1 !mdpe_q);
    fwd_fatal_c: cover property (fwd_err_fatal && serr_en_r ##1 send_fatal_o);
    abort_read_c: cover property (tabt_q && cfg_rd && sts_sel);
    serr_flag_c: cover property (sserr_q && cfg_rd && sts_sel);
endmodule
`default_nettype wire

// ---- ccs_cmd_status_tb.sv ----
// self-checking testbench for the command and status bits
`timescale 1ns/100ps
`default_nettype none
module ccs_cmd_status_tb;
    import ccs_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] cfg_addr = 8'h00;
    logic cfg_wr = 1'h0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [1:0] cfg_be = 2'h0;
    logic cfg_rd = 1'h0;
    logic [15:0] cfg_rdata;
    logic own_int_req = 1'h0;
    logic fwd_int_req = 1'h0;
    logic dev_nonfatal_en = 1'h0;
    logic dev_fatal_en = 1'h0;
    // event pulses share one vector so a single task drives them all
    logic [7:0] ev = 8'h00;
    logic int_assert_o, fwd_int_o, snd_nf, snd_f, snd_c, serr_en_o, perr_resp_o, int_dis_o;
    int err_total = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    ccs_cmd_status DUT (.clk(clk), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .own_int_req(own_int_req), .fwd_int_req(fwd_int_req), .err_nonfatal_det(ev[0]),
        .err_fatal_det(ev[1]), .dev_nonfatal_en(dev_nonfatal_en), .dev_fatal_en(dev_fatal_en),
        .fwd_err_nonfatal(ev[2]), .fwd_err_fatal(ev[3]), .fwd_err_cor(ev[4]),
        .poisoned_cpl_rx(ev[5]), .poisoned_wr_tx(ev[6]), .cpl_abort_tx(ev[7]),
        .int_assert_o(int_assert_o), .fwd_int_o(fwd_int_o), .send_nonfatal_o(snd_nf),
        .send_fatal_o(snd_f), .send_cor_o(snd_c), .serr_en_o(serr_en_o),
        .perr_resp_o(perr_resp_o), .int_dis_o(int_dis_o));
    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_be <= be;
        cfg_wr <= 1'h1;
        @(posedge clk);
        cfg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        cfg_addr <= a;
        cfg_rd <= 1'h1;
        @(posedge clk);
        cfg_rd <= 1'h0;
        #1;
        chk(cfg_rdata, exp);
    endtask
    // message outputs are looked at in the single cycle they stand
    task automatic pulse(input logic [7:0] m, input logic [2:0] exp_snd);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 8'h00;
        #1;
        chk({13'h0000, snd_f, snd_nf, snd_c}, {13'h0000, exp_snd});
    endtask
    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        print_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        rd(CCS_CMD_OFS, 16'h0000);
        rd(CCS_STS_OFS, 16'h0010);
        chk({13'h0000, serr_en_o, perr_resp_o, int_dis_o}, 16'h0000);
        $display("test reset values done");
        wr(CCS_CMD_OFS, 16'hFFFF, 2'h3);
        rd(CCS_CMD_OFS, 16'h0540);
        chk({13'h0000, serr_en_o, perr_resp_o, int_dis_o}, 16'h0007);
        wr(CCS_CMD_OFS, 16'h0000, 2'h3);
        wr(CCS_CMD_OFS, 16'hFFFF, 2'h1);
        rd(CCS_CMD_OFS, 16'h0040);
        wr(CCS_STS_OFS, 16'hFFFF, 2'h3);
        rd(CCS_STS_OFS, 16'h0010);
        wr(8'h08, 16'hFFFF, 2'h3);
        rd(8'h08, 16'h0000);
        $display("test register access done");
        wr(CCS_CMD_OFS, 16'h0000, 2'h3);
        @(posedge clk);
        own_int_req <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, int_assert_o}, 16'h0001);
        rd(CCS_STS_OFS, 16'h0018);
        wr(CCS_CMD_OFS, 16'h0400, 2'h3);
        chk({15'h0000, int_assert_o}, 16'h0000);
        @(posedge clk);
        own_int_req <= 1'h0;
        fwd_int_req <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, fwd_int_o}, 16'h0001);
        rd(CCS_STS_OFS, 16'h0010);
        @(posedge clk);
        fwd_int_req <= 1'h0;
        $display("test interrupt control done");
        // parity flag stays clear while the response bit is off
        wr(CCS_CMD_OFS, 16'h0000, 2'h3);
        pulse(8'h60, 3'h0);
        rd(CCS_STS_OFS, 16'h0010);
        wr(CCS_CMD_OFS, 16'h0040, 2'h3);
        pulse(8'h20, 3'h0);
        rd(CCS_STS_OFS, 16'h0110);
        wr(CCS_STS_OFS, 16'h0000, 2'h3);
        rd(CCS_STS_OFS, 16'h0110);
        wr(CCS_STS_OFS, 16'h0100, 2'h3);
        rd(CCS_STS_OFS, 16'h0010);
        pulse(8'h40, 3'h0);
        rd(CCS_STS_OFS, 16'h0110);
        wr(CCS_STS_OFS, 16'h0100, 2'h3);
        pulse(8'h80, 3'h0);
        rd(CCS_STS_OFS, 16'h0810);
        wr(CCS_STS_OFS, 16'h0800, 2'h3);
        rd(CCS_STS_OFS, 16'h0010);
        $display("test status flags done");
        wr(CCS_CMD_OFS, 16'h0000, 2'h3);
        pulse(8'h02, 3'h0);
        @(posedge clk);
        dev_fatal_en <= 1'h1;
        pulse(8'h02, 3'h4);
        rd(CCS_STS_OFS, 16'h0010);
        pulse(8'h0C, 3'h0);
        pulse(8'h10, 3'h1);
        wr(CCS_CMD_OFS, 16'h0100, 2'h3);
        pulse(8'h01, 3'h2);
        rd(CCS_STS_OFS, 16'h4010);
        pulse(8'h08, 3'h4);
        wr(CCS_STS_OFS, 16'h4000, 2'h3);
        rd(CCS_STS_OFS, 16'h0010);
        $display("test error reporting done");
        // reset in mid-run must clear stored controls and flags alike
        wr(CCS_CMD_OFS, 16'h0540, 2'h3);
        pulse(8'h80, 3'h0);
        @(posedge clk);
        reset_n <= 1'h0;
        repeat (3) @(posedge clk);
        reset_n <= 1'h1;
        rd(CCS_CMD_OFS, 16'h0000);
        rd(CCS_STS_OFS, 16'h0010);
        chk({13'h0000, serr_en_o, perr_resp_o, int_dis_o}, 16'h0000);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
